// ### common/nevq_pkg.sv
// Constants, codes and carrier types for the actuator setting query responder
package nevq_pkg;

	// Result codes placed in the first byte of every answer
	localparam logic [7:0] RC_SUCCESS = 8'h00;
	localparam logic [7:0] RC_UNKNOWN_HANDLE = 8'h80;

	// Handle values that never name an actuator
	localparam logic [15:0] HANDLE_RSVD_LO = 16'h0000;
	localparam logic [15:0] HANDLE_RSVD_HI = 16'hffff;

	// Setting format codes, consecutive from zero
	localparam logic [7:0] FMT_U8 = 8'h00;
	localparam logic [7:0] FMT_S8 = 8'h01;
	localparam logic [7:0] FMT_U16 = 8'h02;
	localparam logic [7:0] FMT_S16 = 8'h03;
	localparam logic [7:0] FMT_U32 = 8'h04;
	localparam logic [7:0] FMT_S32 = 8'h05;
	localparam logic [7:0] FMT_LAST = FMT_S32;

	// Operational state codes, consecutive from zero
	localparam logic [7:0] ST_ACTIVE_CHANGE = 8'h00;
	localparam logic [7:0] ST_ACTIVE_SETTLED = 8'h01;
	localparam logic [7:0] ST_DISABLED = 8'h02;
	localparam logic [7:0] ST_UNAVAILABLE = 8'h03;
	localparam logic [7:0] ST_COND_UNKNOWN = 8'h04;
	localparam logic [7:0] ST_FAILED = 8'h05;
	localparam logic [7:0] ST_INITIALIZING = 8'h06;
	localparam logic [7:0] ST_WINDING_DOWN = 8'h07;
	localparam logic [7:0] ST_UNDER_TEST = 8'h08;
	localparam logic [7:0] ST_LAST = ST_UNDER_TEST;

	// Global register byte offsets
	localparam logic [11:0] REG_STATUS = 12'h000;
	localparam logic [11:0] REG_MASK = 12'h004;
	localparam logic [11:0] REG_SERVED = 12'h008;
	localparam logic [11:0] REG_INFO = 12'h00c;
	// Per-actuator register block: base and word offsets inside it; blocks lie 16 bytes apart
	localparam logic [11:0] REG_ACT_BASE = 12'h010;
	localparam logic [3:0] ACT_HANDLE = 4'h0;
	localparam logic [3:0] ACT_CTRL = 4'h4;
	localparam logic [3:0] ACT_TARGET = 4'h8;
	localparam logic [3:0] ACT_CURRENT = 4'hc;

	// Control word fields
	localparam int CTRL_FMT_LSB = 0;
	localparam int CTRL_STATE_LSB = 8;
	localparam int CTRL_REPORT_LSB = 16;
	// Info word fields
	localparam int INFO_BUSY_BIT = 0;
	localparam int INFO_COUNT_LSB = 8;

	// Status and mask bit positions
	localparam int STAT_W = 2;
	localparam int STAT_SERVED = 0;
	localparam int STAT_UNKNOWN = 1;

	// Reset values
	localparam logic [15:0] RST_HANDLE = HANDLE_RSVD_LO;
	localparam logic [7:0] RST_FMT = FMT_U8;
	localparam logic [7:0] RST_STATE = ST_INITIALIZING;
	localparam logic [31:0] RST_VALUE = 32'h0000_0000;
	localparam logic [STAT_W-1:0] RST_MASK = 2'h0;

	// Answer length figures in bytes
	localparam logic [3:0] HDR_BYTES = 4'h3;
	localparam logic [3:0] ERR_BYTES = 4'h1;

	// Request carrier: one query for one handle
	typedef struct packed {
		logic [15:0] handle;
	} nevq_req_t;

	// Answer carrier: one byte of the answer stream
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} nevq_rsp_t;

	// Captured answer awaiting transmission
	typedef struct packed {
		logic [7:0] code;
		logic [7:0] fmt;
		logic [7:0] state;
		logic [31:0] target;
		logic [31:0] current;
		logic [3:0] len;
	} nevq_frame_t;

endpackage : nevq_pkg

// ### logic/nevq_responder.sv
// Responder that answers actuator setting queries, configured over APB
//
// How it works
// - A query names a 16-bit handle; 0000 and ffff never match an actuator.
// - Answer opens with result code; 80 when no actuator owns the handle.
// - Second byte is the format code: unsigned/signed at 8, 16 or 32 bits.
// - Target setting field is sized by the format code just sent.
// - Current setting field follows, sized by the same format code.
// - Third byte is the actuator's operational state, one of nine codes.
// - Enabled and target differs from current reports change in progress.
// - Enabled and settled sends current setting in both value fields.
// - Outside enabled states the value fields carry stored, meaningless data.
// - Disabled is reported when software sets it, as the enable request does.
// - Unavailable is reported when software sets it for absent equipment.
// - Condition unknown is reported when software sets that code.
// - Failed is reported when software sets that code.
// - Initializing is reported after reset until software sets another code.
// - Winding down is reported when software sets that code.
// - Under test is reported when software sets that code.
`timescale 1ns/1ns

module nevq_responder #(
	parameter int NUM_ACT = 4
) (
	// Clock, reset and clock enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Query input
	input wire logic req_valid,
	input wire nevq_pkg::nevq_req_t req,
	output logic req_ready,
	// Answer byte stream
	output logic rsp_valid,
	output nevq_pkg::nevq_rsp_t rsp,
	input wire logic rsp_ready,
	// Interrupt
	output logic irq
);
	import nevq_pkg::*;

	// Index width and actuator count as software sees it
	localparam int ACT_IW = (NUM_ACT > 1) ? $clog2(NUM_ACT) : 1;
	localparam logic [7:0] ACT_CNT8 = 8'(NUM_ACT);

	// Answer sequencer states: waiting for a query, or sending its bytes
	typedef enum logic {
		RS_IDLE,
		RS_SEND
	} nevq_rs_t;

	// Value field width in bytes for a format code
	function automatic logic [3:0] fmt_bytes(input logic [7:0] fmt);
		logic [3:0] n;
		n = 4'h4;
		case (fmt)
			FMT_U8, FMT_S8: n = 4'h1;
			FMT_U16, FMT_S16: n = 4'h2;
			default: n = 4'h4;
		endcase
		return n;
	endfunction : fmt_bytes

	// Byte idx of an answer frame
	function automatic logic [7:0] frame_byte(input nevq_frame_t f, input logic [3:0] idx);
		logic [3:0] n;
		logic [3:0] k;
		logic [7:0] b;
		n = fmt_bytes(f.fmt);
		k = 4'h0;
		b = 8'h00;
		// Three header bytes, then target and current value bytes, low byte first
		if (idx == 4'h0) begin
			b = f.code;
		end else if (idx == 4'h1) begin
			b = f.fmt;
		end else if (idx == 4'h2) begin
			b = f.state;
		end else if (idx < HDR_BYTES + n) begin
			k = idx - HDR_BYTES;
			b = f.target[{k[1:0], 3'b000} +: 8];
		end else begin
			k = idx - HDR_BYTES - n;
			b = f.current[{k[1:0], 3'b000} +: 8];
		end
		return b;
	endfunction : frame_byte

	// Actuator configuration and setting storage
	logic [15:0] act_handle_q [NUM_ACT];
	logic [15:0] act_handle_d [NUM_ACT];
	logic [7:0] act_fmt_q [NUM_ACT];
	logic [7:0] act_fmt_d [NUM_ACT];
	logic [7:0] act_state_q [NUM_ACT];
	logic [7:0] act_state_d [NUM_ACT];
	logic [31:0] act_target_q [NUM_ACT];
	logic [31:0] act_target_d [NUM_ACT];
	logic [31:0] act_current_q [NUM_ACT];
	logic [31:0] act_current_d [NUM_ACT];
	logic [7:0] act_report [NUM_ACT];

	// Global registers and bus answer flops
	logic [STAT_W-1:0] status_q, status_d;
	logic [STAT_W-1:0] mask_q, mask_d;
	logic [31:0] served_q, served_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic irq_q, irq_d;

	// Answer sequencer state
	nevq_rs_t rs_q, rs_d;
	logic [3:0] idx_q, idx_d;
	nevq_frame_t frame_q, frame_d;
	logic rsp_valid_q, rsp_valid_d;
	nevq_rsp_t rsp_q, rsp_d;
	logic req_ready_q, req_ready_d;
	logic ev_served, ev_unknown;

	// Address decode
	logic [11:0] act_off;
	logic act_hit;
	logic [ACT_IW-1:0] act_idx;
	logic [3:0] act_reg;
	logic bus_setup, bus_done;

	assign act_off = paddr - REG_ACT_BASE;
	assign act_hit = (paddr >= REG_ACT_BASE) && (act_off[11:4] < ACT_CNT8);
	assign act_idx = act_off[4 +: ACT_IW];
	assign act_reg = act_off[3:0];
	// A setup cycle is seen once; the answer flop masks a setup that is already answered
	assign bus_setup = psel && !penable && !pready_q;
	assign bus_done = psel && penable && pready_q;

	// State shown to the requester: enabled states follow the setting motion
	always_comb begin
		for (int i = 0; i < NUM_ACT; i++) begin
			act_report[i] = act_state_q[i];
			if (act_state_q[i] == ST_ACTIVE_CHANGE || act_state_q[i] == ST_ACTIVE_SETTLED) begin
				act_report[i] = (act_target_q[i] != act_current_q[i]) ? ST_ACTIVE_CHANGE : ST_ACTIVE_SETTLED;
			end
		end
	end

	// Register file, bus answer and interrupt next values
	always_comb begin
		act_handle_d = act_handle_q;
		act_fmt_d = act_fmt_q;
		act_state_d = act_state_q;
		act_target_d = act_target_q;
		act_current_d = act_current_q;
		status_d = status_q;
		mask_d = mask_q;
		served_d = served_q;
		prdata_d = prdata_q;
		pslverr_d = pslverr_q;
		pready_d = bus_setup;
		// Read data and error are prepared in the setup cycle
		if (bus_setup) begin
			prdata_d = 32'h0000_0000;
			pslverr_d = 1'b0;
			if (paddr[1:0] != 2'b00) begin
				pslverr_d = 1'b1;
			end else if (paddr == REG_STATUS) begin
				prdata_d[STAT_W-1:0] = status_q;
			end else if (paddr == REG_MASK) begin
				prdata_d[STAT_W-1:0] = mask_q;
			end else if (paddr == REG_SERVED) begin
				prdata_d = served_q;
			end else if (paddr == REG_INFO) begin
				prdata_d[INFO_BUSY_BIT] = (rs_q == RS_SEND);
				prdata_d[INFO_COUNT_LSB +: 8] = ACT_CNT8;
			end else if (act_hit) begin
				case (act_reg)
					ACT_HANDLE: prdata_d[15:0] = act_handle_q[act_idx];
					ACT_CTRL: begin
						prdata_d[CTRL_FMT_LSB +: 8] = act_fmt_q[act_idx];
						prdata_d[CTRL_STATE_LSB +: 8] = act_state_q[act_idx];
						prdata_d[CTRL_REPORT_LSB +: 8] = act_report[act_idx];
					end
					ACT_TARGET: prdata_d = act_target_q[act_idx];
					ACT_CURRENT: prdata_d = act_current_q[act_idx];
					default: pslverr_d = 1'b1;
				endcase
			end else begin
				pslverr_d = 1'b1;
			end
		end
		// Writes take effect at the completing edge
		if (bus_done && pwrite && !pslverr_q) begin
			if (paddr == REG_MASK) begin
				mask_d = pwdata[STAT_W-1:0];
			end else if (act_hit) begin
				case (act_reg)
					ACT_HANDLE: act_handle_d[act_idx] = pwdata[15:0];
					ACT_CTRL: begin
						// Out-of-range codes are dropped, leaving the old value
						if (pwdata[CTRL_FMT_LSB +: 8] <= FMT_LAST) begin
							act_fmt_d[act_idx] = pwdata[CTRL_FMT_LSB +: 8];
						end
						if (pwdata[CTRL_STATE_LSB +: 8] <= ST_LAST) begin
							act_state_d[act_idx] = pwdata[CTRL_STATE_LSB +: 8];
						end
					end
					ACT_TARGET: act_target_d[act_idx] = pwdata;
					ACT_CURRENT: act_current_d[act_idx] = pwdata;
					default: act_target_d = act_target_q;
				endcase
			end
		end
		// A status read clears it; a new event in that cycle still sets
		if (bus_done && !pwrite && paddr == REG_STATUS) begin
			status_d = '0;
		end
		if (ev_served) begin
			status_d[STAT_SERVED] = 1'b1;
			served_d = served_q + 32'h0000_0001;
		end
		if (ev_unknown) begin
			status_d[STAT_UNKNOWN] = 1'b1;
		end
		// Interrupt is taken from next values so it changes in the same cycle as status
		irq_d = |(status_d & mask_d);
	end

	// Register file flops
	// A low clock enable freezes them and stalls an APB access that pready has not yet answered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_ACT; i++) begin
				// Actuators wake initializing, with a handle that matches no query
				act_handle_q[i] <= RST_HANDLE;
				act_fmt_q[i] <= RST_FMT;
				act_state_q[i] <= RST_STATE;
				act_target_q[i] <= RST_VALUE;
				act_current_q[i] <= RST_VALUE;
			end
			status_q <= '0;
			mask_q <= RST_MASK;
			served_q <= 32'h0000_0000;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			irq_q <= 1'b0;
		end else if (ce) begin
			act_handle_q <= act_handle_d;
			act_fmt_q <= act_fmt_d;
			act_state_q <= act_state_d;
			act_target_q <= act_target_d;
			act_current_q <= act_current_d;
			status_q <= status_d;
			mask_q <= mask_d;
			served_q <= served_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			irq_q <= irq_d;
		end
	end

	// Answer sequencer next values
	always_comb begin
		logic found;
		found = 1'b0;
		rs_d = rs_q;
		idx_d = idx_q;
		frame_d = frame_q;
		rsp_valid_d = rsp_valid_q;
		rsp_d = rsp_q;
		req_ready_d = req_ready_q;
		ev_served = 1'b0;
		ev_unknown = 1'b0;
		case (rs_q)
			RS_IDLE: begin
				if (req_valid && req_ready_q) begin
					// Default answer is the one-byte unknown handle reply
					frame_d = '0;
					frame_d.code = RC_UNKNOWN_HANDLE;
					frame_d.len = ERR_BYTES;
					if (req.handle != HANDLE_RSVD_LO && req.handle != HANDLE_RSVD_HI) begin
						// Lowest index wins when two actuators share a handle
						for (int i = 0; i < NUM_ACT; i++) begin
							if (!found && act_handle_q[i] == req.handle) begin
								found = 1'b1;
								frame_d.code = RC_SUCCESS;
								frame_d.fmt = act_fmt_q[i];
								frame_d.state = act_report[i];
								frame_d.current = act_current_q[i];
								// Settled answers repeat the current setting
								if (act_report[i] == ST_ACTIVE_SETTLED) begin
									frame_d.target = act_current_q[i];
								end else begin
									frame_d.target = act_target_q[i];
								end
								frame_d.len = 4'(HDR_BYTES + {fmt_bytes(act_fmt_q[i]), 1'b0});
							end
						end
					end
					// Reserved and unmatched handles both count as unknown
					ev_unknown = !found;
					rsp_valid_d = 1'b1;
					rsp_d.data = frame_byte(frame_d, 4'h0);
					rsp_d.last = (frame_d.len == ERR_BYTES);
					idx_d = 4'h1;
					req_ready_d = 1'b0;
					rs_d = RS_SEND;
				end
			end
			RS_SEND: begin
				// Each byte stands until the sink takes it
				if (rsp_ready) begin
					// Last byte taken: count the answer and free the query input
					if (rsp_q.last) begin
						rsp_valid_d = 1'b0;
						req_ready_d = 1'b1;
						ev_served = 1'b1;
						rs_d = RS_IDLE;
					end else begin
						// Otherwise load the next byte of the captured frame
						rsp_d.data = frame_byte(frame_q, idx_q);
						rsp_d.last = (idx_q + 4'h1 == frame_q.len);
						idx_d = idx_q + 4'h1;
					end
				end
			end
			default: begin
				// Unused state code: fall back to idle, ready for a query
				rs_d = RS_IDLE;
				rsp_valid_d = 1'b0;
				req_ready_d = 1'b1;
			end
		endcase
	end

	// Answer sequencer flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rs_q <= RS_IDLE;
			idx_q <= 4'h0;
			frame_q <= '0;
			rsp_valid_q <= 1'b0;
			rsp_q <= '0;
			req_ready_q <= 1'b1;
		end else if (ce) begin
			rs_q <= rs_d;
			idx_q <= idx_d;
			frame_q <= frame_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_q <= rsp_d;
			req_ready_q <= req_ready_d;
		end
	end

	// Outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign req_ready = req_ready_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp = rsp_q;
	assign irq = irq_q;

endmodule : nevq_responder

// ### bench/nevq_responder_sva.sv
// Port checks for the actuator setting query responder
`timescale 1ns/1ns

module nevq_responder_sva (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Queries, answers, interrupt
	input wire logic req_valid,
	input wire nevq_pkg::nevq_req_t req,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire nevq_pkg::nevq_rsp_t rsp,
	input wire logic rsp_ready,
	input wire logic irq
);
	import nevq_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [3:0] idx_q;
	logic [7:0] code_q;
	logic [7:0] fmt_q;
	logic [3:0] last_idx;

	// Byte position in the answer, keeping its code and format bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_q <= 4'h0;
			code_q <= 8'h00;
			fmt_q <= 8'h00;
		end else if (ce && rsp_valid && rsp_ready) begin
			idx_q <= rsp.last ? 4'h0 : idx_q + 4'h1;
			if (idx_q == 4'h0)
				code_q <= rsp.data;
			if (idx_q == 4'h1)
				fmt_q <= rsp.data;
		end
	end
	// Position of the last byte of a good answer
	assign last_idx = (fmt_q >= FMT_U32) ? 4'ha : (fmt_q >= FMT_U16) ? 4'h6 : 4'h4;

	// Steps of a transfer
	sequence s_take; req_valid && req_ready && ce; endsequence
	sequence s_setup; psel && !penable && ce; endsequence
	sequence s_last; rsp_valid && rsp_ready && ce && rsp.last; endsequence

	property p_apb_ack; s_setup |=> pready; endproperty
	a_apb_ack: assert property (p_apb_ack) else $error("setup not answered next cycle");
	property p_take; s_take |=> rsp_valid && !req_ready && (rsp.data == RC_SUCCESS || rsp.data == RC_UNKNOWN_HANDLE);
	endproperty
	a_take: assert property (p_take) else $error("answer did not open with a result code");
	property p_rsvd; s_take ##0 (req.handle == HANDLE_RSVD_LO || req.handle == HANDLE_RSVD_HI)
		|=> rsp.data == RC_UNKNOWN_HANDLE && rsp.last; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved handle not refused");
	property p_hold; rsp_valid && !rsp_ready && ce |=> rsp_valid && $stable(rsp); endproperty
	a_hold: assert property (p_hold) else $error("answer byte changed while stalled");
	property p_end; s_last |=> !rsp_valid && req_ready; endproperty
	a_end: assert property (p_end) else $error("answer did not end after last byte");
	property p_fmt; rsp_valid && idx_q == 4'h1 && code_q == RC_SUCCESS |-> rsp.data <= FMT_LAST; endproperty
	a_fmt: assert property (p_fmt) else $error("format code out of range");
	property p_state; rsp_valid && idx_q == 4'h2 |-> rsp.data <= ST_LAST; endproperty
	a_state: assert property (p_state) else $error("state code out of range");
	property p_len; rsp_valid && rsp.last && idx_q != 4'h0 |-> code_q == RC_SUCCESS && idx_q == last_idx; endproperty
	a_len: assert property (p_len) else $error("answer length wrong for format");
endmodule : nevq_responder_sva

bind nevq_responder nevq_responder_sva u_sva (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
	.rsp(rsp), .rsp_ready(rsp_ready), .irq(irq));

// ### bench/nevq_mgmt_model.sv
// Management controller model: sends queries and collects answer bytes
`timescale 1ns/1ns

module nevq_mgmt_model (
	// Clock
	input wire logic pclk,
	// Query side
	output logic req_valid,
	output nevq_pkg::nevq_req_t req,
	input wire logic req_ready,
	// Answer side
	input wire logic rsp_valid,
	input wire nevq_pkg::nevq_rsp_t rsp,
	output logic rsp_ready
);
	import nevq_pkg::*;
	logic [7:0] got[$];

	// Idle lines at start
	initial begin
		req_valid = 1'b0;
		req = '{handle: 16'h0};
		rsp_ready = 1'b0;
	end

	// One query; the sink idles stall cycles before each byte
	task automatic query(input logic [15:0] h, input int stall);
		int w;
		got.delete();
		req_valid <= 1'b1;
		req <= '{handle: h};
		do @(posedge pclk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		req <= '{handle: ~h};
		w = stall;
		forever begin
			rsp_ready <= (w == 0);
			@(posedge pclk);
			if (rsp_ready === 1'b1 && rsp_valid === 1'b1) begin
				got.push_back(rsp.data);
				w = stall;
				if (rsp.last)
					break;
			end else if (w > 0) begin
				w--;
			end
		end
		rsp_ready <= 1'b0;
	endtask : query
endmodule : nevq_mgmt_model

// ### bench/tb_nevq_responder.sv
// Self-checking bench for the actuator setting query responder
`timescale 1ns/1ns

module tb_nevq_responder;
	import nevq_pkg::*;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, req_valid, req_ready, rsp_valid, rsp_ready, irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [31:0] tv = 32'h8899aabb;
	logic [31:0] cv = 32'h11223344;
	logic [11:0] ra[6] = '{REG_STATUS, REG_MASK, REG_SERVED, REG_INFO, 12'h014, 12'h018};
	logic [31:0] rv[6] = '{32'h0, 32'h0, 32'h0, 32'h0000_0300, 32'h0006_0600, 32'h0};
	nevq_req_t req;
	nevq_rsp_t rsp;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;

	// Design and controller model
	nevq_responder #(.NUM_ACT(3)) u_nevq_responder (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp(rsp), .rsp_ready(rsp_ready), .irq(irq));
	nevq_mgmt_model m_host (.pclk(pclk), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp(rsp), .rsp_ready(rsp_ready));

	// Clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// Hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
			miscompares++;
		end
	endtask : chk

	// One APB transfer; holds the request until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	function automatic logic [11:0] act(input int i, input logic [3:0] o);
		return REG_ACT_BASE + 12'(16 * i) + 12'(o);
	endfunction : act

	// Good answer against expected format, state and values
	task automatic frame(input int stall, input logic [7:0] f, input logic [7:0] s, input logic vals);
		int n;
		n = (f < FMT_U16) ? 1 : (f < FMT_U32) ? 2 : 4;
		m_host.query(16'h0a51, stall);
		chk("length", m_host.got.size(), 3 + 2 * n);
		chk("result", m_host.got[0], RC_SUCCESS);
		chk("format", m_host.got[1], f);
		chk("state", m_host.got[2], s);
		for (int i = 0; i < n; i++) begin
			if (vals)
				chk("target", m_host.got[3 + i], tv[8 * i +: 8]);
			if (vals)
				chk("current", m_host.got[3 + n + i], cv[8 * i +: 8]);
		end
	endtask : frame

	task automatic unknown(input logic [15:0] h);
		m_host.query(h, 1);
		chk("length", m_host.got.size(), 1);
		chk("result", m_host.got[0], RC_UNKNOWN_HANDLE);
	endtask : unknown

	// Main sequence
	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, ra[i], 32'h0);
			chk("reset value", rd, rv[i]);
			chk("bus error", err, 1'b0);
		end
		apb(1'b0, 12'hffc, 32'h0);
		chk("unmapped error", err, 1'b1);
		chk("unmapped data", rd, 32'h0);
		$display("test reset done");
		unknown(HANDLE_RSVD_LO);
		unknown(HANDLE_RSVD_HI);
		unknown(16'h1234);
		repeat (2) @(posedge pclk);
		chk("irq masked", irq, 1'b0);
		apb(1'b1, REG_MASK, 32'h2);
		@(posedge pclk);
		chk("irq raised", irq, 1'b1);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status", rd, 32'h3);
		@(posedge pclk);
		chk("irq cleared", irq, 1'b0);
		$display("test unknown handle done");
		apb(1'b1, act(1, ACT_HANDLE), 32'h0000_0a51);
		apb(1'b1, act(1, ACT_TARGET), tv);
		apb(1'b1, act(1, ACT_CURRENT), cv);
		for (int f = 0; f < 6; f++) begin
			apb(1'b1, act(1, ACT_CTRL), {16'h0, ST_ACTIVE_SETTLED, 8'(f)});
			frame(f % 3, 8'(f), ST_ACTIVE_CHANGE, 1'b1);
		end
		cv = tv;
		apb(1'b1, act(1, ACT_CURRENT), cv);
		frame(0, FMT_S32, ST_ACTIVE_SETTLED, 1'b1);
		$display("test formats done");
		for (int s = 2; s < 9; s++) begin
			apb(1'b1, act(1, ACT_CTRL), {16'h0, 8'(s), FMT_U16});
			frame(1, FMT_U16, 8'(s), 1'b0);
		end
		apb(1'b0, REG_SERVED, 32'h0);
		chk("served", rd, 32'h11);
		$display("test states done");
		conclude();
	end
endmodule : tb_nevq_responder
